// *** mfra_pkg.sv ***
// Constants shared by the media and floating-point register aliasing block.
package mfra_pkg;

   // ------------------------------------------------------------------
   // Bus register map
   // ------------------------------------------------------------------
   localparam logic [31:0] MFRA_OFF_CTRL = 32'h0000_0000;
   localparam logic [31:0] MFRA_OFF_STATUS = 32'h0000_0004;
   localparam logic [31:0] MFRA_OFF_TAGS = 32'h0000_0008;
   localparam logic [31:0] MFRA_OFF_FAULT = 32'h0000_000c;
   localparam int unsigned MFRA_CTRL_TS_BIT = 0;
   localparam int unsigned MFRA_CTRL_EM_BIT = 1;
   localparam int unsigned MFRA_CTRL_EXC_BIT = 2;
   localparam int unsigned MFRA_CTRL_STEP_BIT = 3;
   localparam logic [3:0] MFRA_CTRL_RST = 4'h0;
   localparam int unsigned MFRA_STAT_PEND_BIT = 0;
   localparam int unsigned MFRA_STAT_TOP_LSB = 11;
   localparam logic [2:0] MFRA_TOP_RST = 3'h0;
   localparam logic [7:0] MFRA_FAULT_RST = 8'h00;

   // ------------------------------------------------------------------
   // Storage layout and tag encodings
   // ------------------------------------------------------------------
   localparam logic [15:0] MFRA_SIGN_EXP_ONES = 16'hffff;
   localparam logic [14:0] MFRA_EXP_MAX = 15'h7fff;
   localparam logic [14:0] MFRA_EXP_ZERO = 15'h0000;
   localparam logic [63:0] MFRA_MANT_ZERO = 64'h0000_0000_0000_0000;
   localparam logic [1:0] MFRA_TAG_VALID = 2'h0;
   localparam logic [1:0] MFRA_TAG_ZERO = 2'h1;
   localparam logic [1:0] MFRA_TAG_SPECIAL = 2'h2;
   localparam logic [1:0] MFRA_TAG_EMPTY = 2'h3;
   localparam logic [15:0] MFRA_TAGW_VALID = 16'h0000;
   localparam logic [15:0] MFRA_TAGW_EMPTY = 16'hffff;

   // ------------------------------------------------------------------
   // Fault vectors and operation codes
   // ------------------------------------------------------------------
   localparam logic [7:0] MFRA_VEC_NONE = 8'h00;
   localparam logic [7:0] MFRA_VEC_BAD_OP = 8'h06;
   localparam logic [7:0] MFRA_VEC_NO_DEV = 8'h07;
   localparam logic [7:0] MFRA_VEC_FP_ERR = 8'h10;
   localparam logic [3:0] MFRA_OP_MEDIA_WR = 4'h0;
   localparam logic [3:0] MFRA_OP_MEDIA_RD = 4'h1;
   localparam logic [3:0] MFRA_OP_EMPTY = 4'h2;
   localparam logic [3:0] MFRA_OP_FP_WR = 4'h3;
   localparam logic [3:0] MFRA_OP_FP_RD = 4'h4;
   localparam logic [3:0] MFRA_OP_FP_TOP = 4'h5;
   localparam logic [3:0] MFRA_OP_STATE_STORE = 4'h6;
   localparam logic [3:0] MFRA_OP_ENV_STORE = 4'h7;
   localparam logic [3:0] MFRA_OP_STATE_RESTORE = 4'h8;
   localparam logic [3:0] MFRA_OP_ENV_LOAD = 4'h9;

   typedef enum logic [1:0] {
      MFRA_OPC_MEDIA = 2'b01,
      MFRA_OPC_FP = 2'b10
   } mfra_class_e;

endpackage : mfra_pkg

// *** mfra_regfile.sv ***
// Shared media and floating-point register file with tag and fault logic.
//
// What this block does
// - Media registers share the floating-point mantissa storage.
// - Media write fills mantissa, sets sign/exponent ones.
// - Floating-point mantissa writes appear in media registers.
// - Media registers use fixed physical locations.
// - Media instructions leave stack top at zero.
// - Stack names relative to top; tags physical.
// - Physical p appears as (p minus top) mod 8.
// - Media instructions except empty set tags valid.
// - Empty instruction sets tags empty, keeps contents.
// - Stored tag word computed from register contents.
// - Media behaviour ignores the tag word.
// - Floating writes set one tag; restores load all.
// - Media read sets tags valid, top zero only.
// - Task switched flag raises vector 7 fault.
// - State store and restore carry media contents.
// - Pending enabled error reported on media instruction.
// - Reported error leaves floating-point state untouched.
// - Emulate flag makes media instructions raise vector 6.
// - Debug stepping applies to media instructions too.
// - Media instructions never touch arithmetic flags.
`timescale 1ns/1ps

module mfra_regfile (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic op_valid,
   input wire logic [3:0] op_code,
   input wire logic [2:0] op_reg,
   input wire logic [79:0] op_wdata,
   input wire logic [15:0] op_tag_load,
   input wire logic [2:0] op_top_load,
   input wire logic op_tag_empty,
   input wire logic fp_exc_raise,
   output logic resp_valid,
   output logic resp_fault,
   output logic [7:0] resp_vector,
   output logic [79:0] resp_data,
   output logic [15:0] resp_tag_word,
   output logic [2:0] stack_top_field,
   output logic fp_error_out,
   output logic flags_write_en,
   output logic debug_trap
);
   import mfra_pkg::*;

   // ------------------------------------------------------------------
   // Shared storage
   // ------------------------------------------------------------------
   // One array serves both datapaths, so a media write and a later
   // floating-point read can never disagree about a mantissa.
   logic [79:0] fp_r [8];
   logic [79:0] fp_nxt [8];
   logic [1:0] tag_r [8];
   logic [1:0] tag_nxt [8];
   logic [2:0] top_r;
   logic [2:0] top_nxt;
   logic [1:0] calc_tag [8];
   logic [15:0] calc_tag_word;
   logic [15:0] tag_word;
   logic [639:0] fp_flat;

   // ------------------------------------------------------------------
   // Bus-side state
   // ------------------------------------------------------------------
   logic [3:0] ctrl_r;
   logic [3:0] ctrl_nxt;
   logic pend_r;
   logic pend_nxt;
   logic [7:0] fault_r;
   logic [7:0] fault_nxt;
   logic wr_pend_r;
   logic wr_pend_nxt;
   logic [3:0] wr_addr_r;
   logic [3:0] wr_addr_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;
   logic hreadyout_r;
   logic fperr_r;
   logic fperr_nxt;

   // ------------------------------------------------------------------
   // Response state
   // ------------------------------------------------------------------
   logic resp_valid_r;
   logic resp_valid_nxt;
   logic resp_fault_r;
   logic resp_fault_nxt;
   logic [7:0] resp_vec_r;
   logic [7:0] resp_vec_nxt;
   logic [79:0] resp_data_r;
   logic [79:0] resp_data_nxt;
   logic [15:0] resp_tag_r;
   logic [15:0] resp_tag_nxt;
   logic trap_r;
   logic trap_nxt;
   logic flags_we_r;

   logic [7:0] op_vec;
   logic is_media;
   logic is_known;
   logic [2:0] exec_phys;
   logic [1:0] op_class;

   // ------------------------------------------------------------------
   // Per-entry tag calculation and flattened views
   // ------------------------------------------------------------------
   for (genvar gi = 0; gi < 8; gi++) begin : g_entry
      assign calc_tag[gi] =
         (tag_r[gi] == MFRA_TAG_EMPTY) ? MFRA_TAG_EMPTY :
         (fp_r[gi][78:64] == MFRA_EXP_MAX) ? MFRA_TAG_SPECIAL :
         (fp_r[gi][78:64] != MFRA_EXP_ZERO) ? MFRA_TAG_VALID :
         (fp_r[gi][63:0] == MFRA_MANT_ZERO) ? MFRA_TAG_ZERO :
         MFRA_TAG_SPECIAL;
      assign calc_tag_word[2*gi+:2] = calc_tag[gi];
      assign tag_word[2*gi+:2] = tag_r[gi];
      assign fp_flat[80*gi+:80] = fp_r[gi];
   end

   // ------------------------------------------------------------------
   // Operation decode and fault priority
   // ------------------------------------------------------------------
   always_comb begin
      is_media = (op_code == MFRA_OP_MEDIA_WR) ||
         (op_code == MFRA_OP_MEDIA_RD) || (op_code == MFRA_OP_EMPTY);
      is_known = op_code <= MFRA_OP_ENV_LOAD;
      op_class = is_media ? MFRA_OPC_MEDIA : MFRA_OPC_FP;
      // Stack-relative names are resolved here; 3-bit wrap is mod 8.
      exec_phys = op_reg + top_r;
      op_vec = MFRA_VEC_NONE;
      if (!is_known) begin
         op_vec = MFRA_VEC_BAD_OP;
      end else if (is_media && ctrl_r[MFRA_CTRL_EM_BIT]) begin
         op_vec = MFRA_VEC_BAD_OP;
      end else if (ctrl_r[MFRA_CTRL_TS_BIT]) begin
         op_vec = MFRA_VEC_NO_DEV;
      end else if (is_media && pend_r && ctrl_r[MFRA_CTRL_EXC_BIT]) begin
         op_vec = MFRA_VEC_FP_ERR;
      end
   end

   // ------------------------------------------------------------------
   // Execution next state
   // ------------------------------------------------------------------
   always_comb begin
      fp_nxt = fp_r;
      tag_nxt = tag_r;
      top_nxt = top_r;
      resp_valid_nxt = op_valid;
      resp_fault_nxt = 1'b0;
      resp_vec_nxt = MFRA_VEC_NONE;
      resp_data_nxt = resp_data_r;
      resp_tag_nxt = resp_tag_r;
      trap_nxt = 1'b0;
      if (op_valid && op_vec != MFRA_VEC_NONE) begin
         // A faulting instruction changes nothing, so the handler sees
         // the state exactly as it stood and can restart the op.
         resp_fault_nxt = 1'b1;
         resp_vec_nxt = op_vec;
      end else if (op_valid) begin
         trap_nxt = ctrl_r[MFRA_CTRL_STEP_BIT];
         if (op_class == MFRA_OPC_MEDIA) begin
            // Media ops index physically and never look at tag_r.
            top_nxt = MFRA_TOP_RST;
            for (int i = 0; i < 8; i++) begin
               tag_nxt[i] = MFRA_TAG_VALID;
            end
         end
         case (op_code)
            MFRA_OP_MEDIA_WR: begin
               fp_nxt[op_reg] = {MFRA_SIGN_EXP_ONES, op_wdata[63:0]};
            end
            MFRA_OP_MEDIA_RD: begin
               resp_data_nxt = {16'h0000, fp_r[op_reg][63:0]};
            end
            MFRA_OP_EMPTY: begin
               for (int i = 0; i < 8; i++) begin
                  tag_nxt[i] = MFRA_TAG_EMPTY;
               end
            end
            MFRA_OP_FP_WR: begin
               fp_nxt[exec_phys] = op_wdata;
               tag_nxt[exec_phys] = op_tag_empty ? MFRA_TAG_EMPTY :
                  MFRA_TAG_VALID;
            end
            MFRA_OP_FP_RD: begin
               resp_data_nxt = fp_r[exec_phys];
            end
            MFRA_OP_FP_TOP: begin
               top_nxt = op_top_load;
            end
            MFRA_OP_STATE_STORE: begin
               resp_data_nxt = fp_r[op_reg];
               resp_tag_nxt = calc_tag_word;
            end
            MFRA_OP_ENV_STORE: begin
               resp_tag_nxt = calc_tag_word;
            end
            MFRA_OP_STATE_RESTORE: begin
               fp_nxt[op_reg] = op_wdata;
               top_nxt = op_top_load;
               for (int i = 0; i < 8; i++) begin
                  tag_nxt[i] = op_tag_load[2*i+:2];
               end
            end
            MFRA_OP_ENV_LOAD: begin
               top_nxt = op_top_load;
               for (int i = 0; i < 8; i++) begin
                  tag_nxt[i] = op_tag_load[2*i+:2];
               end
            end
            default: begin
               resp_data_nxt = resp_data_r;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 8; i++) begin
            fp_r[i] <= 80'h0;
            tag_r[i] <= MFRA_TAG_EMPTY;
         end
         top_r <= MFRA_TOP_RST;
         resp_valid_r <= 1'b0;
         resp_fault_r <= 1'b0;
         resp_vec_r <= MFRA_VEC_NONE;
         resp_data_r <= 80'h0;
         resp_tag_r <= MFRA_TAGW_EMPTY;
         trap_r <= 1'b0;
         flags_we_r <= 1'b0;
      end else begin
         fp_r <= fp_nxt;
         tag_r <= tag_nxt;
         top_r <= top_nxt;
         resp_valid_r <= resp_valid_nxt;
         resp_fault_r <= resp_fault_nxt;
         resp_vec_r <= resp_vec_nxt;
         resp_data_r <= resp_data_nxt;
         resp_tag_r <= resp_tag_nxt;
         trap_r <= trap_nxt;
         // This block never asks for the arithmetic flags to change.
         flags_we_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------------
   // Reads are answered with zero wait states from the next-state values (the tag word from tag_r),
   // so a read right after a write already sees the written value.
   always_comb begin
      wr_pend_nxt = 1'b0;
      wr_addr_nxt = wr_addr_r;
      ctrl_nxt = ctrl_r;
      pend_nxt = pend_r;
      fault_nxt = fault_r;
      hrdata_nxt = hrdata_r;
      if (wr_pend_r && wr_addr_r == MFRA_OFF_CTRL[3:0]) begin
         ctrl_nxt = hwdata[3:0];
      end
      // A new error in the clearing cycle wins over the clear.
      if (wr_pend_r && wr_addr_r == MFRA_OFF_STATUS[3:0] &&
          hwdata[MFRA_STAT_PEND_BIT]) begin
         pend_nxt = 1'b0;
      end
      if (fp_exc_raise) begin
         pend_nxt = 1'b1;
      end
      if (resp_fault_nxt) begin
         fault_nxt = resp_vec_nxt;
      end
      if (hready && hsel && htrans[1]) begin
         wr_pend_nxt = hwrite && (haddr[31:4] == 28'h0);
         wr_addr_nxt = haddr[3:0];
         hrdata_nxt = 32'h0000_0000;
         if (!hwrite && haddr[31:4] == 28'h0) begin
            case (haddr[3:0])
               MFRA_OFF_CTRL[3:0]: hrdata_nxt[3:0] = ctrl_nxt;
               MFRA_OFF_STATUS[3:0]: begin
                  hrdata_nxt[MFRA_STAT_PEND_BIT] = pend_nxt;
                  hrdata_nxt[MFRA_STAT_TOP_LSB+:3] = top_nxt;
               end
               MFRA_OFF_TAGS[3:0]: hrdata_nxt[15:0] = tag_word;
               MFRA_OFF_FAULT[3:0]: hrdata_nxt[7:0] = fault_nxt;
               default: hrdata_nxt = 32'h0000_0000;
            endcase
         end
      end
      fperr_nxt = pend_nxt && ctrl_nxt[MFRA_CTRL_EXC_BIT];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= MFRA_CTRL_RST;
         pend_r <= 1'b0;
         fault_r <= MFRA_FAULT_RST;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 4'h0;
         hrdata_r <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
         fperr_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         pend_r <= pend_nxt;
         fault_r <= fault_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         hrdata_r <= hrdata_nxt;
         hreadyout_r <= 1'b1;
         fperr_r <= fperr_nxt;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
   assign resp_valid = resp_valid_r;
   assign resp_fault = resp_fault_r;
   assign resp_vector = resp_vec_r;
   assign resp_data = resp_data_r;
   assign resp_tag_word = resp_tag_r;
   assign stack_top_field = top_r;
   assign fp_error_out = fperr_r;
   assign flags_write_en = flags_we_r;
   assign debug_trap = trap_r;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_clean_media;
      op_valid && is_media && op_vec == MFRA_VEC_NONE;
   endsequence

   sequence s_clean_op(logic [3:0] code);
      op_valid && op_code == code && op_vec == MFRA_VEC_NONE;
   endsequence

   a_media_sign_exp: assert property (
      s_clean_op(MFRA_OP_MEDIA_WR) |=>
      fp_r[$past(op_reg)] == {MFRA_SIGN_EXP_ONES, $past(op_wdata[63:0])})
      else $error("media write did not set sign and exponent to ones");

   a_media_top_zero: assert property (
      s_clean_media |=> stack_top_field == 3'h0)
      else $error("stack top not zero after media instruction");

   a_media_tags_valid: assert property (
      s_clean_op(MFRA_OP_MEDIA_RD) or s_clean_op(MFRA_OP_MEDIA_WR)
      |=> tag_word == MFRA_TAGW_VALID)
      else $error("media instruction left a tag not valid");

   a_empty_keeps_data: assert property (
      s_clean_op(MFRA_OP_EMPTY) |=>
      tag_word == MFRA_TAGW_EMPTY && fp_flat == $past(fp_flat))
      else $error("empty instruction wrong tags or changed contents");

   a_fault_no_change: assert property (
      op_valid && op_vec != MFRA_VEC_NONE |=>
      resp_fault && $stable(fp_flat) && $stable(tag_word) &&
      $stable(top_r))
      else $error("faulting instruction altered floating-point state");

   a_ts_vector: assert property (
      op_valid && is_known && ctrl_r[MFRA_CTRL_TS_BIT] &&
      !(is_media && ctrl_r[MFRA_CTRL_EM_BIT]) |=>
      resp_fault && resp_vector == MFRA_VEC_NO_DEV)
      else $error("task switched fault not raised with vector 7");

   a_em_vector: assert property (
      op_valid && is_media && ctrl_r[MFRA_CTRL_EM_BIT] |=>
      resp_fault && resp_vector == MFRA_VEC_BAD_OP)
      else $error("emulate flag did not raise vector 6");

   a_pend_report: assert property (
      op_valid && is_media && pend_r && ctrl_r[MFRA_CTRL_EXC_BIT] &&
      ctrl_r[1:0] == 2'b00 |=> resp_vector == MFRA_VEC_FP_ERR && fp_error_out)
      else $error("pending error not reported on media instruction");

   a_fp_wr_map: assert property (
      s_clean_op(MFRA_OP_FP_WR) |=>
      fp_r[$past(exec_phys)] == $past(op_wdata) &&
      $past(exec_phys) == 3'($past(op_reg) + $past(top_r)))
      else $error("stack-relative write landed at wrong entry");

   a_flags_untouched: assert property (
      s_clean_media |=> !flags_write_en [*2])
      else $error("media instruction requested a flags write");

endmodule : mfra_regfile

// *** mfra_core_model.sv ***
// Core-side model that issues register file operations and takes replies.
`timescale 1ns/1ps

module mfra_core_model (
   input wire logic hclk,
   output logic op_valid,
   output logic [3:0] op_code,
   output logic [2:0] op_reg,
   output logic [79:0] op_wdata,
   output logic [15:0] op_tag_load,
   output logic [2:0] op_top_load,
   output logic op_tag_empty,
   output logic fp_exc_raise,
   input wire logic resp_valid,
   input wire logic resp_fault,
   input wire logic [7:0] resp_vector,
   input wire logic [79:0] resp_data,
   input wire logic debug_trap
);
   initial begin
      op_valid = 1'b0;
      op_code = 4'h0;
      op_reg = 3'h0;
      op_wdata = 80'h0;
      op_tag_load = 16'h0;
      op_top_load = 3'h0;
      op_tag_empty = 1'b0;
      fp_exc_raise = 1'b0;
   end

   // ------------------------------------------------------------------
   // One instruction, then wait a bounded time for its reply
   // ------------------------------------------------------------------
   task automatic issue(input logic [3:0] c, input logic [2:0] r,
                        input logic [79:0] w, input logic [15:0] tl,
                        input logic [2:0] tp, input logic te,
                        output logic flt, output logic [7:0] vec,
                        output logic [79:0] dat, output logic trap);
      int n;
      n = 0;
      @(posedge hclk);
      op_valid <= 1'b1;
      op_code <= c;
      op_reg <= r;
      op_wdata <= w;
      op_tag_load <= tl;
      op_top_load <= tp;
      op_tag_empty <= te;
      @(posedge hclk);
      op_valid <= 1'b0;
      // Released payload is scrambled so stale data cannot be relied on.
      op_wdata <= ~w;
      op_tag_load <= ~tl;
      op_top_load <= ~tp;
      #1;
      while (resp_valid !== 1'b1 && n < 8) begin
         @(posedge hclk);
         #1;
         n++;
      end
      flt = resp_fault;
      vec = resp_vector;
      dat = resp_data;
      trap = debug_trap;
   endtask : issue

   task automatic raise_exc();
      @(posedge hclk);
      fp_exc_raise <= 1'b1;
      @(posedge hclk);
      fp_exc_raise <= 1'b0;
   endtask : raise_exc
endmodule : mfra_core_model

// *** tb_media_fp_register_aliasing.sv ***
// Self-checking testbench for the media and floating-point register file.
`timescale 1ns/1ps

module tb_media_fp_register_aliasing;
   import mfra_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic op_valid;
   logic [3:0] op_code;
   logic [2:0] op_reg;
   logic [79:0] op_wdata;
   logic [15:0] op_tag_load;
   logic [2:0] op_top_load;
   logic op_tag_empty;
   logic fp_exc_raise;
   logic resp_valid;
   logic resp_fault;
   logic [7:0] resp_vector;
   logic [79:0] resp_data;
   logic [15:0] resp_tag_word;
   logic [2:0] stack_top_field;
   logic fp_error_out;
   logic flags_write_en;
   logic debug_trap;
   int fails = 0;
   int comparisons = 0;
   logic [31:0] rv;
   logic flt;
   logic [7:0] vec;
   logic [79:0] odat;
   logic trap;
   logic [15:0] tl_g = 16'h0;
   logic [2:0] tp_g = 3'h0;
   logic te_g = 1'b0;
   logic [63:0] m3 = 64'h0123_4567_89ab_cdef;
   logic [79:0] f0 = 80'h4000_1234_5678_9abc_def0;
   logic [79:0] r5 = 80'h3fff_8000_0000_0000_0001;
   logic [3:0] fc [6] = '{4'h2, 4'h1, 4'h1, 4'h0, 4'h3, 4'h4};
   logic [3:0] fo [6] = '{4'h0, 4'h3, 4'h1, 4'hf, 4'h1, 4'h0};
   logic [7:0] fv [6] = '{8'h06, 8'h07, 8'h07, 8'h06, 8'h06, 8'h10};

   always #4 hclk = ~hclk;

   mfra_regfile dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .op_valid(op_valid),
      .op_code(op_code), .op_reg(op_reg), .op_wdata(op_wdata),
      .op_tag_load(op_tag_load), .op_top_load(op_top_load),
      .op_tag_empty(op_tag_empty), .fp_exc_raise(fp_exc_raise),
      .resp_valid(resp_valid), .resp_fault(resp_fault),
      .resp_vector(resp_vector), .resp_data(resp_data),
      .resp_tag_word(resp_tag_word), .stack_top_field(stack_top_field),
      .fp_error_out(fp_error_out), .flags_write_en(flags_write_en),
      .debug_trap(debug_trap));

   mfra_core_model core (.hclk(hclk), .op_valid(op_valid),
      .op_code(op_code), .op_reg(op_reg), .op_wdata(op_wdata),
      .op_tag_load(op_tag_load), .op_top_load(op_top_load),
      .op_tag_empty(op_tag_empty), .fp_exc_raise(fp_exc_raise),
      .resp_valid(resp_valid), .resp_fault(resp_fault),
      .resp_vector(resp_vector), .resp_data(resp_data),
      .debug_trap(debug_trap));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input logic [79:0] e,
                      input logic [79:0] g);
      comparisons++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rv = hrdata;
   endtask : bus

   task automatic rreg(input logic [31:0] a, input logic [31:0] e,
                       input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, {48'h0, e}, {48'h0, rv});
      chk("hresp", 80'h0, {79'h0, hresp});
   endtask : rreg

   task automatic op(input logic [3:0] c, input logic [2:0] r,
                     input logic [79:0] w);
      core.issue(c, r, w, tl_g, tp_g, te_g, flt, vec, odat, trap);
      chk("resp_valid", 80'h1, {79'h0, resp_valid});
      chk("flags_en", 80'h0, {79'h0, flags_write_en});
   endtask : op

   task automatic final_report();
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rreg(MFRA_OFF_TAGS, 32'h0000_ffff, "tags_rst");
      rreg(MFRA_OFF_CTRL, 32'h0, "ctrl_rst");
      bus(1'b1, 32'h0000_0010, 32'hffff_ffff);
      rreg(32'h0000_0010, 32'h0, "unmapped");
      op(MFRA_OP_MEDIA_WR, 3'h3, {16'h1234, m3});
      op(MFRA_OP_MEDIA_RD, 3'h3, 80'h0);
      chk("media_rd", {16'h0, m3}, odat);
      rreg(MFRA_OFF_TAGS, 32'h0, "tags_valid");
      op(MFRA_OP_STATE_STORE, 3'h3, 80'h0);
      chk("sign_exp", {16'hffff, m3}, odat);
      chk("tag_calc", 80'h5595, {64'h0, resp_tag_word});
      op(MFRA_OP_EMPTY, 3'h0, 80'h0);
      rreg(MFRA_OFF_TAGS, 32'h0000_ffff, "tags_empty");
      tp_g = 3'h2;
      op(MFRA_OP_FP_TOP, 3'h0, 80'h0);
      rreg(MFRA_OFF_STATUS, 32'h0000_1000, "top_two");
      op(MFRA_OP_FP_WR, 3'h6, f0);
      rreg(MFRA_OFF_TAGS, 32'h0000_fffc, "one_tag");
      op(MFRA_OP_FP_RD, 3'h1, 80'h0);
      chk("stack_rel", {16'hffff, m3}, odat);
      op(MFRA_OP_MEDIA_RD, 3'h0, 80'h0);
      chk("alias", {16'h0, f0[63:0]}, odat);
      chk("top_zero", 80'h0, {77'h0, stack_top_field});
      rreg(MFRA_OFF_TAGS, 32'h0, "rd_tags");
      tl_g = 16'h1b4e;
      tp_g = 3'h5;
      op(MFRA_OP_STATE_RESTORE, 3'h5, r5);
      rreg(MFRA_OFF_TAGS, 32'h0000_1b4e, "tags_load");
      chk("top_load", 80'h5, {77'h0, stack_top_field});
      op(MFRA_OP_STATE_STORE, 3'h5, 80'h0);
      chk("restore", r5, odat);
      core.raise_exc();
      // A faulting instruction must leave tags and stack top untouched.
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, MFRA_OFF_CTRL, {28'h0, fc[i]});
         op(fo[i], 3'h1, 80'h0);
         chk("fault_vec", {72'h0, fv[i]}, {72'h0, vec});
         chk("fault", 80'h1, {79'h0, flt});
      end
      rreg(MFRA_OFF_TAGS, 32'h0000_1b4e, "tags_kept");
      chk("top_kept", 80'h5, {77'h0, stack_top_field});
      chk("err_out", 80'h1, {79'h0, fp_error_out});
      rreg(MFRA_OFF_STATUS, 32'h0000_2801, "pending");
      rreg(MFRA_OFF_FAULT, 32'h0000_0010, "last_vec");
      bus(1'b1, MFRA_OFF_CTRL, 32'h0000_0008);
      bus(1'b1, MFRA_OFF_STATUS, 32'h0000_0001);
      rreg(MFRA_OFF_STATUS, 32'h0000_2800, "pend_clr");
      chk("err_clr", 80'h0, {79'h0, fp_error_out});
      op(MFRA_OP_MEDIA_WR, 3'h7, 80'h5);
      chk("step", 80'h1, {79'h0, trap});
      chk("no_fault", 80'h0, {79'h0, flt});
      chk("top_after", 80'h0, {77'h0, stack_top_field});
      final_report();
   end

   // Generous bound: the sequence needs a few hundred cycles at most.
   initial begin
      repeat (3000) @(posedge hclk);
      fails++;
      final_report();
   end
endmodule : tb_media_fp_register_aliasing
